// ===== cct_timer.sv
// cct_timer: capture/compare/pwm timer with up to four channels and event outputs
// assumes channel pins and external count input are asynchronous; config ports static-ish
//
// Notes on behaviour
// - normal variant uses a sixteen-bit counter with up to four channels.
// - wide variant behaves the same with a thirty-two-bit counter.
// - each channel runs in capture, compare or pwm mode, chosen independently.
// - capture copies the counter into the channel buffer on the chosen edge.
// - compare drives the channel output from the counter versus threshold match.
// - pwm output shape follows successive compare values written by software.
// - dead-time insertion exists only on the first instance of each variant.
// - counter may count external events; trigger pulses go to event routing.
`timescale 1ns/1ps
`default_nettype none
module cct_timer #(
	parameter int WIDTH = cct_pkg::CCT_NORMAL_WIDTH,
	parameter int CHANNELS = cct_pkg::CCT_MAX_CHANNELS,
	parameter bit FIRST_INSTANCE = 1'b1
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// counter control
	input wire logic RUN,
	input wire cct_pkg::cct_src_e SOURCE,
	input wire logic [cct_pkg::CCT_PRESC_WIDTH-1:0] PRESCALE,
	input wire logic [WIDTH-1:0] TOP,
	input wire logic EXT_COUNT,
	// channel configuration
	input wire cct_pkg::cct_chan_cfg_s [CHANNELS-1:0] CHAN_CFG,
	input wire logic [CHANNELS-1:0][WIDTH-1:0] COMPARE_VALUE,
	input wire logic [CHANNELS-1:0] COMPARE_WRITE,
	// dead time
	input wire logic DEAD_ENABLE,
	input wire logic [cct_pkg::CCT_DEAD_WIDTH-1:0] DEAD_CYCLES,
	// channel pins
	input wire logic [CHANNELS-1:0] CHAN_IN,
	output logic [CHANNELS-1:0] CHAN_OUT,
	output logic [CHANNELS-1:0] CHAN_OUT_N,
	output logic [CHANNELS-1:0] CHAN_OE,
	// capture buffers and status
	output logic [CHANNELS-1:0][WIDTH-1:0] CAPTURE_VALUE,
	output logic [WIDTH-1:0] COUNT,
	output logic WRAP_FLAG,
	output logic [CHANNELS-1:0] MATCH_FLAG,
	input wire logic WRAP_CLEAR,
	input wire logic [CHANNELS-1:0] MATCH_CLEAR,
	// event routing network triggers
	output logic EVT_WRAP,
	output logic [CHANNELS-1:0] EVT_CHAN
);
	// elaboration checks on the parameters
	if (WIDTH != cct_pkg::CCT_NORMAL_WIDTH && WIDTH != cct_pkg::CCT_WIDE_WIDTH) begin : g_bad_width
		$error("WIDTH must be the normal or wide counter width");
	end
	if (CHANNELS < 1 || CHANNELS > cct_pkg::CCT_MAX_CHANNELS) begin : g_bad_channels
		$error("CHANNELS out of range");
	end

	function automatic logic edge_hit(input cct_pkg::cct_edge_e sel, input logic now,
			input logic prev);
		logic rise;
		logic fall;
		rise = now & ~prev;
		fall = ~now & prev;
		case (sel)
			cct_pkg::CCT_EDGE_RISE: edge_hit = rise;
			cct_pkg::CCT_EDGE_FALL: edge_hit = fall;
			cct_pkg::CCT_EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	// synchronisers for pins
	logic [CHANNELS-1:0] in_meta, in_sync, in_prev;
	logic ext_meta, ext_sync, ext_prev;
	logic [cct_pkg::CCT_PRESC_WIDTH-1:0] presc;
	logic [CHANNELS-1:0][WIDTH-1:0] compare_active;
	logic [CHANNELS-1:0][WIDTH-1:0] compare_buffer;
	logic [CHANNELS-1:0] buffer_valid;
	logic [CHANNELS-1:0] level;

	// tick selection: prescaler or external events
	wire presc_tick = presc == PRESCALE;
	wire ext_rise = ext_sync & ~ext_prev;
	wire ext_fall = ~ext_sync & ext_prev;
	wire ext_tick = (SOURCE == cct_pkg::CCT_SRC_EXT_RISE) ? ext_rise :
		(SOURCE == cct_pkg::CCT_SRC_EXT_FALL) ? ext_fall : (ext_rise | ext_fall);
	wire tick = RUN & ((SOURCE == cct_pkg::CCT_SRC_PRESCALE) ? presc_tick : ext_tick);
	wire at_top = COUNT == TOP;
	wire wrap = tick & at_top;
	wire [WIDTH-1:0] next_count = wrap ? '0 : COUNT + 1'b1;

	// per-channel decode
	logic [CHANNELS-1:0] cap_hit, cmp_hit, is_cap, is_cmp, is_pwm;
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			is_cap[i] = CHAN_CFG[i].mode == cct_pkg::CCT_MODE_CAPTURE;
			is_cmp[i] = CHAN_CFG[i].mode == cct_pkg::CCT_MODE_COMPARE;
			is_pwm[i] = CHAN_CFG[i].mode == cct_pkg::CCT_MODE_PWM;
			cap_hit[i] = is_cap[i] & edge_hit(CHAN_CFG[i].edge_sel, in_sync[i], in_prev[i]);
			cmp_hit[i] = (is_cmp[i] | is_pwm[i]) & tick & (COUNT == compare_active[i]);
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			in_meta <= '0;
			in_sync <= '0;
			in_prev <= '0;
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			in_meta <= CHAN_IN;
			in_sync <= in_meta;
			in_prev <= in_sync;
			ext_meta <= EXT_COUNT;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			presc <= '0;
			COUNT <= '0;
			WRAP_FLAG <= 1'b0;
			EVT_WRAP <= 1'b0;
		end else begin
			presc <= (presc_tick | ~RUN) ? '0 : presc + 1'b1;
			if (tick)
				COUNT <= next_count;
			// set wins over clear
			WRAP_FLAG <= wrap | (WRAP_FLAG & ~WRAP_CLEAR);
			EVT_WRAP <= wrap;
		end
	end

	// channel state
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CAPTURE_VALUE <= '0;
			MATCH_FLAG <= '0;
			EVT_CHAN <= '0;
			compare_active <= '0;
			compare_buffer <= '0;
			buffer_valid <= '0;
			level <= '0;
			CHAN_OE <= '0;
		end else begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (cap_hit[i])
					CAPTURE_VALUE[i] <= COUNT;
				MATCH_FLAG[i] <= cap_hit[i] | cmp_hit[i] | (MATCH_FLAG[i] & ~MATCH_CLEAR[i]);
				EVT_CHAN[i] <= cap_hit[i] | cmp_hit[i];
				CHAN_OE[i] <= is_cmp[i] | is_pwm[i];
				// pwm loads buffered compare at wrap so each period uses one value
				if (COMPARE_WRITE[i]) begin
					compare_buffer[i] <= COMPARE_VALUE[i];
					buffer_valid[i] <= 1'b1;
				end else if (wrap & buffer_valid[i] & is_pwm[i]) begin
					buffer_valid[i] <= 1'b0;
				end
				if (is_pwm[i]) begin
					if (wrap & buffer_valid[i])
						compare_active[i] <= compare_buffer[i];
				end else if (COMPARE_WRITE[i]) begin
					compare_active[i] <= COMPARE_VALUE[i];
				end
				if (is_pwm[i]) begin
					if (wrap)
						level[i] <= 1'b1;
					else if (cmp_hit[i])
						level[i] <= 1'b0;
				end else if (is_cmp[i] & cmp_hit[i]) begin
					case (CHAN_CFG[i].act)
						cct_pkg::CCT_ACT_TOGGLE: level[i] <= ~level[i];
						cct_pkg::CCT_ACT_CLEAR: level[i] <= 1'b0;
						cct_pkg::CCT_ACT_SET: level[i] <= 1'b1;
						default: level[i] <= level[i];
					endcase
				end else if (~is_cmp[i]) begin
					level[i] <= 1'b0;
				end
			end
		end
	end

	// output stage, dead time only on the first instance
	for (genvar g = 0; g < CHANNELS; g++) begin : g_out
		if (FIRST_INSTANCE) begin : g_dead
			cct_dead_time #(
				.DW(cct_pkg::CCT_DEAD_WIDTH)
			) u_dead (
				.clk(CLK),
				.rst(RST),
				.enable(DEAD_ENABLE & is_pwm[g]),
				.dead_cycles(DEAD_CYCLES),
				.level(level[g]),
				.out_high(CHAN_OUT[g]),
				.out_low(CHAN_OUT_N[g])
			);
		end else begin : g_plain
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					CHAN_OUT[g] <= 1'b0;
					CHAN_OUT_N[g] <= 1'b0;
				end else begin
					CHAN_OUT[g] <= level[g];
					CHAN_OUT_N[g] <= ~level[g];
				end
			end
		end
	end
endmodule : cct_timer
`default_nettype wire

// ===== cct_pkg.sv
// cct_pkg: shared constants, types and channel configuration for the capture/compare/pwm timer
// assumes one clock domain; configuration arrives as plain ports (no software registers)
package cct_pkg;
	// channel modes
	typedef enum logic [1:0] {
		CCT_MODE_OFF = 2'h0,
		CCT_MODE_CAPTURE = 2'h1,
		CCT_MODE_COMPARE = 2'h3,
		CCT_MODE_PWM = 2'h2
	} cct_mode_e;
	// capture edge select
	typedef enum logic [1:0] {
		CCT_EDGE_RISE = 2'h0,
		CCT_EDGE_FALL = 2'h1,
		CCT_EDGE_BOTH = 2'h2,
		CCT_EDGE_NONE = 2'h3
	} cct_edge_e;
	// compare output action on match
	typedef enum logic [1:0] {
		CCT_ACT_NONE = 2'h0,
		CCT_ACT_TOGGLE = 2'h1,
		CCT_ACT_CLEAR = 2'h2,
		CCT_ACT_SET = 2'h3
	} cct_act_e;
	// counter tick source
	typedef enum logic [1:0] {
		CCT_SRC_PRESCALE = 2'h0,
		CCT_SRC_EXT_RISE = 2'h1,
		CCT_SRC_EXT_FALL = 2'h2,
		CCT_SRC_EXT_BOTH = 2'h3
	} cct_src_e;
	// per-channel configuration
	typedef struct packed {
		cct_mode_e mode;
		cct_edge_e edge_sel;
		cct_act_e act;
	} cct_chan_cfg_s;
	localparam int CCT_NORMAL_WIDTH = 16;
	localparam int CCT_WIDE_WIDTH = 32;
	localparam int CCT_MAX_CHANNELS = 4;
	localparam int CCT_PRESC_WIDTH = 10;
	localparam int CCT_DEAD_WIDTH = 8;
	localparam int CCT_SYNC_STAGES = 2;
	localparam logic [1:0] CCT_RESET_MODE = 2'h0;
endpackage : cct_pkg

// ===== cct_dead_time.sv
// cct_dead_time: splits one modulated level into a complementary pair with dead time
// assumes the level input is registered in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module cct_dead_time #(
	parameter int DW = cct_pkg::CCT_DEAD_WIDTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic enable,
	input wire logic [DW-1:0] dead_cycles,
	input wire logic level,
	// pair
	output logic out_high,
	output logic out_low
);
	logic last;
	logic [DW-1:0] hold;
	wire changed = level != last;
	wire idle = hold == '0;
	wire next_high = enable ? (level & idle & ~changed) : level;
	wire next_low = enable ? (~level & idle & ~changed) : ~level;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last <= 1'b0;
			hold <= '0;
			out_high <= 1'b0;
			out_low <= 1'b0;
		end else begin
			last <= level;
			// both sides held low for dead_cycles+1 cycles after each change
			hold <= changed ? dead_cycles : (idle ? hold : hold - 1'b1);
			out_high <= next_high;
			out_low <= next_low;
		end
	end
endmodule : cct_dead_time
`default_nettype wire

// ===== cct_timer_assertions.sv
// cct_timer_assertions: port checks for the timer
// assumes bound to cct_timer, four channels, one clock
`timescale 1ns/1ps
`default_nettype none
module cct_timer_assertions #(
	parameter int WIDTH = 16,
	parameter int CHANNELS = 4
) (
	// control
	input wire logic CLK,
	input wire logic RST,
	input wire logic RUN,
	input wire cct_pkg::cct_src_e SOURCE,
	input wire logic [cct_pkg::CCT_PRESC_WIDTH-1:0] PRESCALE,
	input wire logic [WIDTH-1:0] TOP,
	input wire cct_pkg::cct_chan_cfg_s [CHANNELS-1:0] CHAN_CFG,
	input wire logic WRAP_CLEAR,
	// observed
	input wire logic [CHANNELS-1:0] CHAN_OUT,
	input wire logic [CHANNELS-1:0] CHAN_OUT_N,
	input wire logic [CHANNELS-1:0] CHAN_OE,
	input wire logic [CHANNELS-1:0][WIDTH-1:0] CAPTURE_VALUE,
	input wire logic [WIDTH-1:0] COUNT,
	input wire logic WRAP_FLAG,
	input wire logic [CHANNELS-1:0] MATCH_FLAG,
	input wire logic EVT_WRAP,
	input wire logic [CHANNELS-1:0] EVT_CHAN
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire tick = RUN && PRESCALE == 10'h0 && SOURCE == cct_pkg::CCT_SRC_PRESCALE;
	sequence s_top;
		tick && COUNT == TOP;
	endsequence
	a_count_step: assert property (tick && COUNT != TOP |=> COUNT == $past(COUNT) + 1'b1)
		else $error("no count step");
	a_wrap_zero: assert property (s_top |=> COUNT == '0 && EVT_WRAP && WRAP_FLAG)
		else $error("no wrap");
	a_wrap_pulse: assert property (EVT_WRAP |=> !EVT_WRAP)
		else $error("long wrap event");
	a_stop_hold: assert property (!RUN |=> $stable(COUNT))
		else $error("count moved");
	a_flag_sticky: assert property (WRAP_FLAG && !WRAP_CLEAR |=> WRAP_FLAG)
		else $error("flag lost");
	a_off_quiet: assert property
		(CHAN_CFG[3].mode == cct_pkg::CCT_MODE_OFF |-> !CHAN_OE[3] && !CHAN_OUT[3])
		else $error("off channel drives");
	a_capture_copy: assert property
		(EVT_CHAN[0] && CHAN_CFG[0].mode == cct_pkg::CCT_MODE_CAPTURE
		|-> CAPTURE_VALUE[0] == $past(COUNT) && MATCH_FLAG[0])
		else $error("bad capture");
	a_pair_compl: assert property
		(CHAN_CFG[1].mode == cct_pkg::CCT_MODE_COMPARE && !$past(RST) |-> CHAN_OUT_N[1] == !CHAN_OUT[1])
		else $error("pair not complement");
endmodule : cct_timer_assertions
bind cct_timer cct_timer_assertions #(.WIDTH(WIDTH), .CHANNELS(CHANNELS)) chk_u (
	.CLK(CLK),
	.RST(RST),
	.RUN(RUN),
	.SOURCE(SOURCE),
	.PRESCALE(PRESCALE),
	.TOP(TOP),
	.CHAN_CFG(CHAN_CFG),
	.WRAP_CLEAR(WRAP_CLEAR),
	.CHAN_OUT(CHAN_OUT),
	.CHAN_OUT_N(CHAN_OUT_N),
	.CHAN_OE(CHAN_OE),
	.CAPTURE_VALUE(CAPTURE_VALUE),
	.COUNT(COUNT),
	.WRAP_FLAG(WRAP_FLAG),
	.MATCH_FLAG(MATCH_FLAG),
	.EVT_WRAP(EVT_WRAP),
	.EVT_CHAN(EVT_CHAN)
);
`default_nettype wire

// ===== cct_timer_tb_top.sv
// cct_timer_tb_top: self-checking bench with a counter model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
module cct_timer_tb_top;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic RUN = 1'b0;
	cct_pkg::cct_src_e SOURCE = cct_pkg::CCT_SRC_PRESCALE;
	logic [9:0] PRESCALE = 10'h0;
	logic [15:0] TOP = 16'h9;
	logic EXT_COUNT = 1'b0;
	// off, pwm, compare toggle, capture rise
	cct_pkg::cct_chan_cfg_s [3:0] CHAN_CFG = 24'h32cf50;
	logic [3:0][15:0] COMPARE_VALUE = '0;
	logic [3:0] COMPARE_WRITE = 4'h0;
	logic DEAD_ENABLE = 1'b1;
	logic [7:0] DEAD_CYCLES = 8'h2;
	logic [3:0] CHAN_IN = 4'h0;
	logic WRAP_CLEAR = 1'b0;
	logic [3:0] MATCH_CLEAR = 4'h0;
	logic [3:0] CHAN_OUT, CHAN_OUT_N, CHAN_OE, MATCH_FLAG, EVT_CHAN;
	logic [3:0][15:0] CAPTURE_VALUE;
	logic [15:0] COUNT;
	logic WRAP_FLAG, EVT_WRAP;
	// wide variant, not the first instance, so no dead time
	wire [31:0] TOP_W = {16'h0, TOP};
	wire [3:0][31:0] COMPARE_VALUE_W = {16'h0, COMPARE_VALUE[3], 16'h0, COMPARE_VALUE[2],
		16'h0, COMPARE_VALUE[1], 16'h0, COMPARE_VALUE[0]};
	logic [3:0] CHAN_OUT_W, CHAN_OUT_N_W, CHAN_OE_W, MATCH_FLAG_W, EVT_CHAN_W;
	logic [3:0][31:0] CAPTURE_VALUE_W;
	logic [31:0] COUNT_W;
	logic WRAP_FLAG_W, EVT_WRAP_W;
	logic x0 = 1'b0, x1 = 1'b0, x2 = 1'b0, xt = 1'b0;
	logic po = 1'b0;
	int err_count = 0, checks = 0, m = 0, top, pw, hits = 0, tog = 0, runs = 0, hl = 0, cd = 0, cap;
	int hw = 0;
	cct_timer dut_u (
		.CLK(CLK), .RST(RST), .RUN(RUN), .SOURCE(SOURCE), .PRESCALE(PRESCALE), .TOP(TOP),
		.EXT_COUNT(EXT_COUNT), .CHAN_CFG(CHAN_CFG), .COMPARE_VALUE(COMPARE_VALUE),
		.COMPARE_WRITE(COMPARE_WRITE), .DEAD_ENABLE(DEAD_ENABLE), .DEAD_CYCLES(DEAD_CYCLES),
		.CHAN_IN(CHAN_IN), .CHAN_OUT(CHAN_OUT), .CHAN_OUT_N(CHAN_OUT_N), .CHAN_OE(CHAN_OE),
		.CAPTURE_VALUE(CAPTURE_VALUE), .COUNT(COUNT), .WRAP_FLAG(WRAP_FLAG),
		.MATCH_FLAG(MATCH_FLAG), .WRAP_CLEAR(WRAP_CLEAR), .MATCH_CLEAR(MATCH_CLEAR),
		.EVT_WRAP(EVT_WRAP), .EVT_CHAN(EVT_CHAN)
	);
	cct_timer #(
		.WIDTH(cct_pkg::CCT_WIDE_WIDTH),
		.CHANNELS(4),
		.FIRST_INSTANCE(1'b0)
	) dut_wide_u (
		.CLK(CLK), .RST(RST), .RUN(RUN), .SOURCE(SOURCE), .PRESCALE(PRESCALE), .TOP(TOP_W),
		.EXT_COUNT(EXT_COUNT), .CHAN_CFG(CHAN_CFG), .COMPARE_VALUE(COMPARE_VALUE_W),
		.COMPARE_WRITE(COMPARE_WRITE), .DEAD_ENABLE(DEAD_ENABLE), .DEAD_CYCLES(DEAD_CYCLES),
		.CHAN_IN(CHAN_IN), .CHAN_OUT(CHAN_OUT_W), .CHAN_OUT_N(CHAN_OUT_N_W), .CHAN_OE(CHAN_OE_W),
		.CAPTURE_VALUE(CAPTURE_VALUE_W), .COUNT(COUNT_W), .WRAP_FLAG(WRAP_FLAG_W),
		.MATCH_FLAG(MATCH_FLAG_W), .WRAP_CLEAR(WRAP_CLEAR), .MATCH_CLEAR(MATCH_CLEAR),
		.EVT_WRAP(EVT_WRAP_W), .EVT_CHAN(EVT_CHAN_W)
	);
	initial begin
		forever #2 CLK = ~CLK;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		if (err_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize
	task automatic step;
		logic t;
		@(posedge CLK);
		#1;
		// two-flop synchroniser and edge detect of the count input
		xt = (SOURCE == cct_pkg::CCT_SRC_EXT_RISE) ? (x1 & ~x2) :
			(SOURCE == cct_pkg::CCT_SRC_EXT_FALL) ? (~x1 & x2) : (x1 ^ x2);
		t = RUN && (SOURCE == cct_pkg::CCT_SRC_PRESCALE || xt);
		x2 = x1;
		x1 = x0;
		x0 = EXT_COUNT;
		COMPARE_WRITE = 4'h0;
		WRAP_CLEAR = 1'b0;
		if (t && m == 3) hits++;
		if (t) m = (m == top) ? 0 : m + 1;
		check(COUNT, 16'(m));
		check(COUNT_W[15:0], 16'(m));
		check(COUNT_W[31:16], 16'h0);
		check(EVT_WRAP, 16'(t && m == 0));
		check(EVT_WRAP_W, 16'(t && m == 0));
		check(16'(CHAN_OUT_W[2] ^ CHAN_OUT_N_W[2]), 16'h1);
		check(16'(CHAN_OUT[2] & CHAN_OUT_N[2]), 16'h0);
		if (CHAN_OUT[1] !== po) tog++;
		po = CHAN_OUT[1];
		if (CHAN_OUT[2]) hl++;
		if (CHAN_OUT_W[2]) hw++;
		if (!CHAN_OUT[2] && hl > 0) begin
			// dead time takes DEAD_CYCLES+1 cycles off the high side
			if (SOURCE == cct_pkg::CCT_SRC_PRESCALE) begin
				check(16'(hl), 16'(pw - DEAD_CYCLES));
				check(16'(hw), 16'(pw + 1));
			end
			hl = 0;
			hw = 0;
			runs++;
			if (runs == 2) begin
				pw = top - 1 - pw;
				COMPARE_VALUE[2] = 16'(pw);
				COMPARE_WRITE = 4'h4;
			end
		end
		if (cd > 0) cd++;
		if (cd == 3) cap = m;
		if (cd == 5) check(CAPTURE_VALUE[0], 16'(cap));
		if (cd == 5) check(CAPTURE_VALUE_W[0][15:0], 16'(cap));
		if (cd == 5) check(MATCH_FLAG[0], 16'h1);
		if (cd == 5) check(MATCH_FLAG_W[0], 16'h1);
	endtask : step
	initial begin
		#10000;
		err_count++;
		summarize();
	end
	initial begin
		void'($urandom(79));
		top = 8 + $urandom % 8;
		pw = 4 + $urandom % (top - 7);
		TOP = 16'(top);
		repeat (8) @(posedge CLK);
		#1;
		RST = 1'b0;
		COMPARE_VALUE[1] = 16'h3;
		COMPARE_VALUE[2] = 16'(pw);
		COMPARE_WRITE = 4'h6;
		step();
		RUN = 1'b1;
		for (int i = 0; i < 150; i++) begin
			step();
			if (i == 20) begin
				CHAN_IN[0] = 1'b1;
				cd = 1;
			end
			if (i == 30) WRAP_CLEAR = 1'b1;
			if (i == 31) check(WRAP_FLAG, 16'(m == 0));
			if (i == 31) check(WRAP_FLAG_W, 16'(m == 0));
		end
		// external event counting
		SOURCE = cct_pkg::cct_src_e'(2'(1 + $urandom % 3));
		for (int i = 0; i < 80; i++) begin
			step();
			if (i % 2 == 0) EXT_COUNT = ~EXT_COUNT;
		end
		RUN = 1'b0;
		repeat (4) step();
		check(16'(tog), 16'(hits));
		check(16'(runs > 2), 16'h1);
		check(CHAN_OE, 16'h6);
		check(CHAN_OE_W, 16'h6);
		summarize();
	end
endmodule : cct_timer_tb_top
`default_nettype wire
